// File: pkg/spr_pkg.sv
`default_nettype none

package spr_pkg;

    // ==========================================================
    // Widths and selector codes
    // ==========================================================
    localparam int unsigned XLEN = 32;
    localparam int unsigned SEL_W = 3;
    localparam logic [SEL_W-1:0] SEL_PROGRAM_COUNTER = 3'h0;
    localparam logic [SEL_W-1:0] SEL_MACHINE_STATUS = 3'h1;
    localparam logic [SEL_W-1:0] SEL_EXCEPTION_ADDRESS = 3'h3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [XLEN-1:0] PROGRAM_COUNTER_RESET = 32'h00000000;
    localparam logic [XLEN-1:0] MACHINE_STATUS_RESET = 32'h00000000;
    localparam logic [XLEN-1:0] EXCEPTION_ADDRESS_RESET = 32'h00000000;
    localparam logic [XLEN-1:0] ZERO_WORD = 32'h00000000;

    // ==========================================================
    // Status field positions, numbered with bit 0 as the MSB
    // ==========================================================
    localparam int unsigned POS_CARRY_MIRROR = 0;
    localparam int unsigned POS_EXCEPTION_ACTIVE = 22;
    localparam int unsigned POS_EXCEPTION_GATE = 23;
    localparam int unsigned POS_DATA_CACHE_ON = 24;
    localparam int unsigned POS_INT_DIVIDE_ZERO = 25;
    localparam int unsigned POS_INSTR_CACHE_ON = 26;
    localparam int unsigned POS_STREAM_LINK_ERROR = 27;
    localparam int unsigned POS_BREAK_ACTIVE = 28;
    localparam int unsigned POS_CARRY = 29;
    localparam int unsigned POS_INTERRUPT_GATE = 30;
    localparam int unsigned POS_BUSLOCK_ON = 31;

    // Vector index of a printed position
    function automatic int unsigned vidx(input int unsigned pos);
        return XLEN - 1 - pos;
    endfunction : vidx

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic move_from_special;
        logic move_to_special;
        logic status_bit_set_instr;
        logic status_bit_clear_instr;
        logic [SEL_W-1:0] special_selector;
        logic [XLEN-1:0] operand;
    } spr_cmd_t;

    typedef struct packed {
        logic int_divide_zero;
        logic stream_link_mismatch;
        logic sw_break;
        logic external_break;
        logic external_nonmaskable_break;
        logic break_return;
        logic exception_take;
        logic exception_addr_valid;
        logic return_from_exception;
    } spr_event_t;

    typedef struct packed {
        logic buslock_on;
        logic interrupt_gate;
        logic carry;
        logic break_active;
        logic stream_link_error;
        logic instr_cache_on;
        logic int_divide_zero_flag;
        logic data_cache_on;
        logic exception_gate;
        logic exception_active;
    } status_view_t;

endpackage : spr_pkg

`default_nettype wire

// File: logic/cpu_special_purpose_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01: Program counter holds the 32-bit address of the instruction now executing.
// RULE_02: Program counter reads with selector 000; move-to-special cannot change it.
// RULE_03: Status read returns carry at bit 29 and a copy at bit 0.
// RULE_04: Status written by move-to-special selector 001 and by bit set/clear instructions.
// RULE_05: Carry updates at once; other writable status bits one cycle later.
// RULE_06: Anything written to status bit 0 is discarded; it only mirrors carry.
// RULE_07: Bit 22 reads 1 while a hardware exception is handled; software may write.
// RULE_08: Bit 23 gates hardware exceptions, 1 allows them, resets to 0.
// RULE_09: Bit 24 enables data cache, bit 26 instruction cache; both reset off.
// RULE_10: Bit 25 set on integer divide by zero, regardless of exception support.
// RULE_11: Bit 27 set on stream-link get/put instruction and value type mismatch.
// RULE_12: Bit 28 shows break in progress from software, external or nonmaskable break.
// RULE_13: Bit 30 enables interrupts when 1; resets to 0.
// RULE_14: Bit 31 enables bus locking on the data-side peripheral bus only.
// RULE_15: Exception address captures the faulting load/store address on exception.
// RULE_16: Exception address reads with selector 011.
// RULE_17: Return from exception sets exception gate, clears active bit and status.
// RULE_18: Reserved status bits 1 to 21 read zero and ignore writes.
// RULE_19: Exception address is read-only to moves; only exception capture changes it.
module cpu_special_purpose_regs (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic instr_valid_in,
    input wire logic [spr_pkg::XLEN-1:0] exec_pc_in,
    input wire spr_pkg::spr_cmd_t cmd_in,
    input wire logic alu_carry_valid_in,
    input wire logic alu_carry_in,
    input wire spr_pkg::spr_event_t event_in,
    input wire logic [spr_pkg::XLEN-1:0] fault_address_in,
    output logic read_valid_out,
    output logic [spr_pkg::XLEN-1:0] read_data_out,
    output logic [spr_pkg::XLEN-1:0] program_counter_out,
    output logic [spr_pkg::XLEN-1:0] exception_address_out,
    output spr_pkg::status_view_t status_out,
    output logic exception_accept_out,
    output logic esr_clear_out,
    output logic peripheral_bus_lock_out
);
    import spr_pkg::*;

    // ==========================================================
    // Field masks
    // ==========================================================
    function automatic logic [XLEN-1:0] bit_at(input int unsigned pos);
        logic [XLEN-1:0] m;
        m = ZERO_WORD;
        m[vidx(pos)] = 1'b1;
        return m;
    endfunction : bit_at

    // Carry lives in its own flop, so it is kept out of the delayed mask
    localparam logic [XLEN-1:0] DELAYED_MASK =
        bit_at(POS_EXCEPTION_ACTIVE) | bit_at(POS_EXCEPTION_GATE) |
        bit_at(POS_DATA_CACHE_ON) | bit_at(POS_INT_DIVIDE_ZERO) |
        bit_at(POS_INSTR_CACHE_ON) | bit_at(POS_STREAM_LINK_ERROR) |
        bit_at(POS_BREAK_ACTIVE) | bit_at(POS_INTERRUPT_GATE) |
        bit_at(POS_BUSLOCK_ON);
    localparam logic [XLEN-1:0] CARRY_MASK =
        bit_at(POS_CARRY) | bit_at(POS_CARRY_MIRROR);

    // ==========================================================
    // State
    // ==========================================================
    logic [XLEN-1:0] program_counter;
    logic [XLEN-1:0] machine_status;
    logic [XLEN-1:0] exception_address;
    logic carry;
    logic pend_valid;
    logic [XLEN-1:0] pend_value;

    logic [XLEN-1:0] status_view;
    logic [XLEN-1:0] write_base;
    logic [XLEN-1:0] next_image;
    logic status_write;
    logic exc_accept;
    logic any_break;
    logic [XLEN-1:0] event_set;
    logic [XLEN-1:0] event_clear;
    logic [XLEN-1:0] next_machine_status;
    logic [XLEN-1:0] next_read_data;

    // ==========================================================
    // Status view as software sees it
    // ==========================================================
    always_comb begin
        status_view = machine_status & DELAYED_MASK; // [RULE_18]
        if (carry) begin
            status_view = status_view | CARRY_MASK; // [RULE_03]
        end
    end

    // ==========================================================
    // Write decode
    // ==========================================================
    assign status_write = (cmd_in.move_to_special &&
                           cmd_in.special_selector == SEL_MACHINE_STATUS) ||
                          cmd_in.status_bit_set_instr ||
                          cmd_in.status_bit_clear_instr; // [RULE_04]

    // Back-to-back writes build on the value still waiting to land
    always_comb begin
        write_base = pend_valid ? (pend_value | (carry ? CARRY_MASK : ZERO_WORD))
                                : status_view;
        if (cmd_in.move_to_special) begin
            next_image = cmd_in.operand;
        end else if (cmd_in.status_bit_set_instr) begin
            next_image = write_base | cmd_in.operand;
        end else if (cmd_in.status_bit_clear_instr) begin
            next_image = write_base & ~cmd_in.operand;
        end else begin
            next_image = write_base;
        end
    end

    // ==========================================================
    // Hardware events
    // ==========================================================
    assign exc_accept = event_in.exception_take &&
                        machine_status[vidx(POS_EXCEPTION_GATE)]; // [RULE_08]
    assign any_break = event_in.sw_break || event_in.external_break ||
                       event_in.external_nonmaskable_break; // [RULE_12]

    always_comb begin
        event_set = ZERO_WORD;
        event_clear = ZERO_WORD;
        if (event_in.int_divide_zero) begin
            event_set = event_set | bit_at(POS_INT_DIVIDE_ZERO); // [RULE_10]
        end
        if (event_in.stream_link_mismatch) begin
            event_set = event_set | bit_at(POS_STREAM_LINK_ERROR); // [RULE_11]
        end
        if (any_break) begin
            event_set = event_set | bit_at(POS_BREAK_ACTIVE); // [RULE_12]
        end else if (event_in.break_return) begin
            event_clear = event_clear | bit_at(POS_BREAK_ACTIVE);
        end
        if (exc_accept) begin
            event_set = event_set | bit_at(POS_EXCEPTION_ACTIVE); // [RULE_07]
            event_clear = event_clear | bit_at(POS_EXCEPTION_GATE);
        end else if (event_in.return_from_exception) begin
            event_set = event_set | bit_at(POS_EXCEPTION_GATE); // [RULE_17]
            event_clear = event_clear | bit_at(POS_EXCEPTION_ACTIVE); // [RULE_17]
        end
    end

    // Sets are applied last so a flag raised while software clears it stays up
    always_comb begin
        next_machine_status = pend_valid ? pend_value : machine_status; // [RULE_05]
        next_machine_status = next_machine_status & ~event_clear;
        next_machine_status = (next_machine_status | event_set) & DELAYED_MASK; // [RULE_18]
    end

    // ==========================================================
    // Carry: takes effect on the write edge
    // ==========================================================
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            carry <= MACHINE_STATUS_RESET[vidx(POS_CARRY)];
        end else if (status_write) begin
            carry <= next_image[vidx(POS_CARRY)]; // [RULE_05] [RULE_06]
        end else if (alu_carry_valid_in) begin
            carry <= alu_carry_in;
        end
    end

    // ==========================================================
    // Delayed write stage for the other status bits
    // ==========================================================
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_valid <= 1'b0;
            pend_value <= MACHINE_STATUS_RESET;
        end else begin
            pend_valid <= status_write; // [RULE_05]
            // Bit 0 and reserved bits never enter the stage
            pend_value <= (next_image & DELAYED_MASK) | event_set; // [RULE_06] [RULE_18]
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            machine_status <= MACHINE_STATUS_RESET; // [RULE_08] [RULE_09] [RULE_13]
        end else begin
            machine_status <= next_machine_status;
        end
    end

    // ==========================================================
    // Program counter
    // ==========================================================
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            program_counter <= PROGRAM_COUNTER_RESET;
        end else if (instr_valid_in) begin
            program_counter <= exec_pc_in; // [RULE_01] [RULE_02]
        end
    end

    // ==========================================================
    // Exception address
    // ==========================================================
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            exception_address <= EXCEPTION_ADDRESS_RESET;
        end else if (exc_accept && event_in.exception_addr_valid) begin
            exception_address <= fault_address_in; // [RULE_15] [RULE_19]
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_comb begin
        case (cmd_in.special_selector)
            SEL_PROGRAM_COUNTER: begin
                // The reading instruction's own address, not the last one
                next_read_data = exec_pc_in; // [RULE_01] [RULE_02]
            end
            SEL_MACHINE_STATUS: begin
                next_read_data = status_view; // [RULE_03]
            end
            SEL_EXCEPTION_ADDRESS: begin
                next_read_data = exception_address; // [RULE_16]
            end
            default: begin
                next_read_data = ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            read_valid_out <= 1'b0;
            read_data_out <= ZERO_WORD;
        end else begin
            read_valid_out <= cmd_in.move_from_special;
            if (cmd_in.move_from_special) begin
                read_data_out <= next_read_data;
            end
        end
    end

    // ==========================================================
    // Side effects
    // ==========================================================
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            esr_clear_out <= 1'b0;
        end else begin
            esr_clear_out <= event_in.return_from_exception && !exc_accept; // [RULE_17]
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign program_counter_out = program_counter;
    assign exception_address_out = exception_address;
    assign exception_accept_out = exc_accept;
    // Only the data-side peripheral bus sees the lock
    assign peripheral_bus_lock_out = machine_status[vidx(POS_BUSLOCK_ON)]; // [RULE_14]

    always_comb begin
        status_out.buslock_on = machine_status[vidx(POS_BUSLOCK_ON)];
        status_out.interrupt_gate = machine_status[vidx(POS_INTERRUPT_GATE)]; // [RULE_13]
        status_out.carry = carry;
        status_out.break_active = machine_status[vidx(POS_BREAK_ACTIVE)];
        status_out.stream_link_error = machine_status[vidx(POS_STREAM_LINK_ERROR)];
        status_out.instr_cache_on = machine_status[vidx(POS_INSTR_CACHE_ON)]; // [RULE_09]
        status_out.int_divide_zero_flag = machine_status[vidx(POS_INT_DIVIDE_ZERO)];
        status_out.data_cache_on = machine_status[vidx(POS_DATA_CACHE_ON)]; // [RULE_09]
        status_out.exception_gate = machine_status[vidx(POS_EXCEPTION_GATE)];
        status_out.exception_active = machine_status[vidx(POS_EXCEPTION_ACTIVE)]; // [RULE_07]
    end

endmodule : cpu_special_purpose_regs

`default_nettype wire

// File: tb/spr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker for the special register block
module spr_monitor (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [spr_pkg::XLEN-1:0] exec_pc_in,
    input wire spr_pkg::spr_cmd_t cmd_in,
    input wire spr_pkg::spr_event_t event_in,
    input wire logic [spr_pkg::XLEN-1:0] fault_address_in,
    input wire logic read_valid_out,
    input wire logic [spr_pkg::XLEN-1:0] read_data_out,
    input wire logic [spr_pkg::XLEN-1:0] exception_address_out,
    input wire spr_pkg::status_view_t status_out,
    input wire logic exception_accept_out,
    input wire logic esr_clear_out,
    input wire logic peripheral_bus_lock_out
);
    import spr_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic rd_pc;
    logic rd_st;
    logic wr_st;
    assign rd_pc = cmd_in.move_from_special && cmd_in.special_selector == SEL_PROGRAM_COUNTER;
    assign rd_st = cmd_in.move_from_special && cmd_in.special_selector == SEL_MACHINE_STATUS;
    assign wr_st = cmd_in.move_to_special && cmd_in.special_selector == SEL_MACHINE_STATUS;
    property p_read_valid; cmd_in.move_from_special |=> read_valid_out; endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("read strobe missing");
    property p_pc_read; rd_pc |=> read_data_out == $past(exec_pc_in); endproperty
    a_pc_read: assert property (p_pc_read)
        else $error("program counter read wrong");
    property p_mirror; rd_st |=> read_data_out[31] == read_data_out[2]; endproperty
    a_mirror: assert property (p_mirror)
        else $error("carry copy differs");
    property p_reserved; rd_st |=> read_data_out[30:10] == 21'h000000; endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits set");
    property p_carry_now; wr_st |=> status_out.carry == $past(cmd_in.operand[2]); endproperty
    a_carry_now: assert property (p_carry_now)
        else $error("carry not updated at once");
    // Unaccepted exceptions must leave the address alone, whatever the moves do
    property p_ear_hold;
        !(exception_accept_out && event_in.exception_addr_valid) |=> $stable(exception_address_out);
    endproperty
    a_ear_hold: assert property (p_ear_hold)
        else $error("exception address changed");
    property p_accept; exception_accept_out == (event_in.exception_take && status_out.exception_gate); endproperty
    a_accept: assert property (p_accept)
        else $error("exception gating wrong");
    property p_entry; exception_accept_out |=> status_out.exception_active; endproperty
    a_entry: assert property (p_entry)
        else $error("exception active not set");
    property p_capture;
        exception_accept_out && event_in.exception_addr_valid |=> exception_address_out == $past(fault_address_in);
    endproperty
    a_capture: assert property (p_capture)
        else $error("fault address not captured");
    property p_return;
        event_in.return_from_exception && !exception_accept_out
            |=> status_out.exception_gate && !status_out.exception_active && esr_clear_out;
    endproperty
    a_return: assert property (p_return)
        else $error("return from exception wrong");
    property p_div0; event_in.int_divide_zero |=> status_out.int_divide_zero_flag; endproperty
    a_div0: assert property (p_div0)
        else $error("divide flag not set");
    property p_lock; peripheral_bus_lock_out == status_out.buslock_on; endproperty
    a_lock: assert property (p_lock)
        else $error("bus lock differs from status");
endmodule : spr_monitor
`default_nettype wire

// File: tb/spr_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Pipeline side: issues one instruction per call
module spr_pipe_model (
    input wire logic sys_clk_in,
    output spr_pkg::spr_cmd_t cmd_out,
    output spr_pkg::spr_event_t event_out,
    output logic instr_valid_out,
    output logic [spr_pkg::XLEN-1:0] exec_pc_out,
    output logic [spr_pkg::XLEN-1:0] fault_address_out,
    output logic alu_carry_valid_out,
    output logic alu_carry_out
);
    import spr_pkg::*;
    initial begin
        cmd_out = '0;
        event_out = '0;
        instr_valid_out = 1'b0;
        exec_pc_out = 32'h00000000;
        fault_address_out = 32'h00000000;
        alu_carry_valid_out = 1'b0;
        alu_carry_out = 1'b0;
    end
    // Released data fields show inverted data and strobes drop to zero so a stale value is never mistaken for live
    task automatic go(input spr_cmd_t c, input spr_event_t e, input logic [XLEN-1:0] pc,
                      input logic [XLEN-1:0] fa, input logic cv, input logic cb);
        @(posedge sys_clk_in);
        #1;
        cmd_out = c;
        event_out = e;
        instr_valid_out = 1'b1;
        exec_pc_out = pc;
        fault_address_out = fa;
        alu_carry_valid_out = cv;
        alu_carry_out = cb;
        @(posedge sys_clk_in);
        #1;
        cmd_out = '{special_selector: ~c.special_selector, operand: ~c.operand, default: 1'b0};
        event_out = '0;
        instr_valid_out = 1'b0;
        exec_pc_out = ~pc;
        fault_address_out = ~fa;
        alu_carry_valid_out = 1'b0;
        alu_carry_out = ~cb;
    endtask : go
endmodule : spr_pipe_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spr_pkg::*;
    // ==========================================================
    // Wiring
    logic sys_clk_in;
    logic reset_n_in;
    spr_cmd_t cmd;
    spr_event_t ev;
    logic instr_valid;
    logic [XLEN-1:0] exec_pc;
    logic [XLEN-1:0] fault_address;
    logic carry_valid;
    logic carry;
    logic read_valid;
    logic [XLEN-1:0] read_data;
    logic [XLEN-1:0] pc_view;
    logic [XLEN-1:0] ear_view;
    status_view_t status;
    logic accept;
    logic esr_clear;
    logic bus_lock;
    int fail_count = 0;
    int checks_done = 0;
    typedef struct packed {
        logic wen;
        logic [2:0] wsel;
        logic [31:0] wdata;
        logic [2:0] rsel;
        logic [31:0] pc;
        logic [31:0] exp;
    } row_t;
    // Write (optional) then read back; status writes settle within two cycles
    row_t rows [8] = '{
        '{1'b1, 3'h1, 32'hFFFFFFFF, 3'h1, 32'h00000010, 32'h800003FF},
        '{1'b1, 3'h1, 32'h80000000, 3'h1, 32'h00000014, 32'h00000000},
        '{1'b1, 3'h1, 32'h00000004, 3'h1, 32'h00000018, 32'h80000004},
        '{1'b0, 3'h0, 32'h00000000, 3'h0, 32'h12345678, 32'h12345678},
        '{1'b1, 3'h0, 32'hFFFFFFFF, 3'h0, 32'hA5A50000, 32'hA5A50000},
        '{1'b1, 3'h3, 32'hFFFFFFFF, 3'h3, 32'h00000020, 32'h00000000},
        '{1'b0, 3'h0, 32'h00000000, 3'h2, 32'h00000024, 32'h00000000},
        '{1'b1, 3'h1, 32'h7FFFFC00, 3'h1, 32'h00000028, 32'h00000000}};
    cpu_special_purpose_regs dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .instr_valid_in(instr_valid), .exec_pc_in(exec_pc), .cmd_in(cmd),
        .alu_carry_valid_in(carry_valid), .alu_carry_in(carry), .event_in(ev),
        .fault_address_in(fault_address), .read_valid_out(read_valid), .read_data_out(read_data),
        .program_counter_out(pc_view), .exception_address_out(ear_view), .status_out(status),
        .exception_accept_out(accept), .esr_clear_out(esr_clear),
        .peripheral_bus_lock_out(bus_lock));
    spr_pipe_model u_pipe (.sys_clk_in(sys_clk_in), .cmd_out(cmd), .event_out(ev),
        .instr_valid_out(instr_valid), .exec_pc_out(exec_pc), .fault_address_out(fault_address),
        .alu_carry_valid_out(carry_valid), .alu_carry_out(carry));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // ==========================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic read_check(input logic [2:0] sel, input logic [31:0] pc, input logic [31:0] exp);
        u_pipe.go('{move_from_special: 1'b1, special_selector: sel, default: 1'b0}, '0, pc, 32'h0, 1'b0, 1'b0);
        check("read_valid", 32'h1, {31'h0, read_valid});
        check("read_data", exp, read_data);
        check("pc_view", pc, pc_view);
    endtask : read_check
    task automatic st(input logic mt, input logic set, input logic clr, input logic [31:0] op);
        u_pipe.go('{move_to_special: mt, status_bit_set_instr: set, status_bit_clear_instr: clr,
                    special_selector: SEL_MACHINE_STATUS, operand: op, default: 1'b0},
                  '0, 32'h300, 32'h0, 1'b0, 1'b0);
    endtask : st
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (3000) @(posedge sys_clk_in);
        fail_count++;
        finish_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        reset_n_in = 1'b0;
        repeat (8) @(posedge sys_clk_in);
        #1 reset_n_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (rows[i].wen)
                u_pipe.go('{move_to_special: 1'b1, special_selector: rows[i].wsel,
                            operand: rows[i].wdata, default: 1'b0}, '0, 32'h100, 32'h0, 1'b0, 1'b0);
            repeat (3) @(posedge sys_clk_in);
            read_check(rows[i].rsel, rows[i].pc, rows[i].exp);
        end
        $display("table rows done");
        st(1'b1, 1'b0, 1'b0, 32'h00000084);
        check("carry_first", 32'h1, {31'h0, status.carry});
        check("dcache_late", 32'h0, {31'h0, status.data_cache_on});
        @(posedge sys_clk_in);
        #1;
        check("dcache_on", 32'h1, {31'h0, status.data_cache_on});
        u_pipe.go('0, '0, 32'h304, 32'h0, 1'b1, 1'b0);
        check("alu_carry", 32'h0, {31'h0, status.carry});
        st(1'b0, 1'b0, 1'b1, 32'h00000080);
        repeat (2) @(posedge sys_clk_in);
        check("dcache_clr", 32'h0, {31'h0, status.data_cache_on});
        $display("write timing done");
        u_pipe.go('0, '{exception_take: 1'b1, exception_addr_valid: 1'b1, default: 1'b0},
                  32'h308, 32'h11111111, 1'b0, 1'b0);
        check("gated_off", 32'h0, {31'h0, status.exception_active});
        st(1'b0, 1'b1, 1'b0, 32'h00000100);
        repeat (2) @(posedge sys_clk_in);
        u_pipe.go('0, '{exception_take: 1'b1, exception_addr_valid: 1'b1, default: 1'b0},
                  32'h30C, 32'hDEADBEE0, 1'b0, 1'b0);
        check("entry", 32'h2, {30'h0, status.exception_active, status.exception_gate});
        read_check(SEL_EXCEPTION_ADDRESS, 32'h310, 32'hDEADBEE0);
        u_pipe.go('0, '{return_from_exception: 1'b1, default: 1'b0}, 32'h314, 32'h0, 1'b0, 1'b0);
        check("return", 32'h6, {29'h0, esr_clear, status.exception_gate, status.exception_active});
        $display("exception done");
        u_pipe.go('0, '{int_divide_zero: 1'b1, stream_link_mismatch: 1'b1, sw_break: 1'b1,
                  default: 1'b0}, 32'h318, 32'h0, 1'b0, 1'b0);
        check("flags", 32'h7, {29'h0, status.int_divide_zero_flag, status.stream_link_error,
              status.break_active});
        u_pipe.go('0, '{break_return: 1'b1, default: 1'b0}, 32'h31C, 32'h0, 1'b0, 1'b0);
        check("brk_return", 32'h0, {31'h0, status.break_active});
        u_pipe.go('0, '{external_nonmaskable_break: 1'b1, default: 1'b0}, 32'h320, 32'h0, 1'b0, 1'b0);
        check("nm_break", 32'h1, {31'h0, status.break_active});
        u_pipe.go('0, '{break_return: 1'b1, default: 1'b0}, 32'h324, 32'h0, 1'b0, 1'b0);
        u_pipe.go('0, '{external_break: 1'b1, default: 1'b0}, 32'h328, 32'h0, 1'b0, 1'b0);
        check("ext_break", 32'h1, {31'h0, status.break_active});
        $display("events done");
        reset_n_in = 1'b0;
        @(posedge sys_clk_in);
        #1;
        check("reset_status", 32'h0, {22'h0, status});
        check("reset_ear", 32'h0, ear_view);
        reset_n_in = 1'b1;
        read_check(SEL_MACHINE_STATUS, 32'h400, 32'h00000000);
        $display("reset done");
        finish_test();
    end
endmodule : testbench
bind cpu_special_purpose_regs spr_monitor u_mon (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .exec_pc_in(exec_pc_in), .cmd_in(cmd_in), .event_in(event_in),
    .fault_address_in(fault_address_in), .read_valid_out(read_valid_out),
    .read_data_out(read_data_out), .exception_address_out(exception_address_out),
    .status_out(status_out), .exception_accept_out(exception_accept_out),
    .esr_clear_out(esr_clear_out), .peripheral_bus_lock_out(peripheral_bus_lock_out));
`default_nettype wire
